//--- logic/modem_settings_pkg.sv
// constants, field layout and state type of the modem settings bank
package modem_settings_pkg;

   // ***************************************************
   // setting numbers and storage slots
   // ***************************************************
   localparam int unsigned num_settings       = 12;
   localparam logic [4:0]  idx_long_timer     = 5'h12;
   localparam logic [4:0]  idx_short_timer    = 5'h13;
   localparam logic [4:0]  idx_spare_a        = 5'h14;
   localparam logic [4:0]  idx_bert_options   = 5'h15;
   localparam logic [4:0]  idx_calling        = 5'h16;
   localparam logic [4:0]  idx_guard_tone     = 5'h17;
   localparam logic [4:0]  idx_eq_clock       = 5'h18;
   localparam logic [4:0]  idx_tx_format      = 5'h19;
   localparam logic [4:0]  idx_rx_format      = 5'h1a;
   localparam logic [4:0]  idx_line_standard  = 5'h1b;
   localparam logic [4:0]  idx_twist          = 5'h1c;
   localparam logic [4:0]  idx_spare_b        = 5'h1d;
   localparam logic [4:0]  idx_first          = idx_long_timer;
   localparam logic [4:0]  idx_last           = idx_spare_b;

   localparam int sl_long_timer    = 0;
   localparam int sl_short_timer   = 1;
   localparam int sl_bert_options  = 3;
   localparam int sl_calling       = 4;
   localparam int sl_guard_tone    = 5;
   localparam int sl_eq_clock      = 6;
   localparam int sl_tx_format     = 7;
   localparam int sl_rx_format     = 8;
   localparam int sl_line_standard = 9;
   localparam int sl_twist         = 10;

   // ***************************************************
   // profile values, slot 0 (long timer) in the low byte
   // ***************************************************
   localparam logic [num_settings-1:0][7:0] profile0_values = {
      8'h00, 8'h00, 8'h00, 8'h30, 8'hb0, 8'h01,
      8'h00, 8'h00, 8'hc1, 8'h00, 8'h02, 8'h1e};
   localparam logic [num_settings-1:0][7:0] profile1_values = {
      8'h00, 8'h00, 8'h00, 8'hb0, 8'hb0, 8'h03,
      8'h00, 8'h00, 8'hc1, 8'h00, 8'h02, 8'h1e};

   // ***************************************************
   // field positions
   // ***************************************************
   localparam int bert_end_bit   = 0;
   localparam int bert_band_bit  = 1;
   localparam int two_bit_lsb    = 6;  // scrambler, guard tone, parity, overspeed
   localparam int calling_lsb    = 5;
   localparam int eq_xtal_bit    = 0;
   localparam int eq_fixed_bit   = 1;
   localparam int eq_auto_bit    = 2;
   localparam int fmt_gain_lsb   = 0;
   localparam int fmt_char_lsb   = 3;
   localparam int std_lsb        = 4;
   localparam int twist_lsb      = 0;

   // ***************************************************
   // codes and decode tables
   // ***************************************************
   localparam logic [1:0] scr_on_detect   = 2'h3;
   localparam logic [1:0] scr_on_nodetect = 2'h2;
   localparam logic [1:0] guard_none      = 2'h0;
   localparam logic [1:0] guard_550hz     = 2'h3;
   localparam logic [1:0] guard_1800hz    = 2'h2;
   localparam logic [1:0] parity_odd      = 2'h0;
   localparam logic [1:0] parity_even     = 2'h1;
   localparam logic [1:0] parity_none     = 2'h2;
   localparam logic [1:0] ospeed_2p3      = 2'h0;
   localparam logic [1:0] ospeed_1p0      = 2'h1;
   localparam logic [1:0] ospeed_none     = 2'h2;
   localparam logic [2:0] gain_max_code   = 3'h7;
   localparam logic [4:0] half_db_per_step = 5'h03;
   localparam logic [3:0] min_data_bits   = 4'h5;
   localparam logic [1:0] min_stop_bits   = 2'h1;
   localparam logic [3:0] std_max_code    = 4'h9;
   localparam logic [3:0] board_mod_min   = 4'h2;
   localparam logic [2:0] twist_default   = 3'h0;
   // calling level per 3-bit code; unlisted codes fall back to level 0
   localparam logic [7:0][2:0] calling_level_table = {
      3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
   localparam logic [7:0] calling_code_legal = 8'hf1;
   // twist in 0.5 dB units per code: +2.0 +1.0 +1.5 +2.5 +3.0 .. +4.5
   localparam logic [7:0][3:0] twist_half_db_table = {
      4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h3, 4'h2, 4'h4};

   // ***************************************************
   // state of the bank
   // ***************************************************
   typedef struct packed {
      logic [num_settings-1:0][7:0] setting;
      logic [7:0]                   rd_data;
      logic                         rd_valid;
   } bank_state_t;

endpackage : modem_settings_pkg

//--- logic/gain_step_decoder.sv
// turns a 3-bit gain code into attenuation in 0.5 dB units
`timescale 1ns/100ps
`default_nettype none
module gain_step_decoder
   import modem_settings_pkg::*;
(
   input  wire logic [2:0] code,
   output logic      [4:0] atten_half_db
);

   logic [2:0] steps_below_max;

   // each code below the top one loses 1.5 dB
   assign steps_below_max = gain_max_code - code;
   assign atten_half_db   = 5'({2'h0, steps_below_max} * half_db_per_step);

endmodule : gain_step_decoder
`default_nettype wire

//--- logic/modem_settings_register_bank.sv
// settings bank for the line modem transceiver, with decoded configuration outputs
//
// Overview of operation
// - two 8-bit timers, seconds default 30 and 10 ms units default 2
// - test options bit 0 picks receiving end (0) or transmitting end (1)
// - test options bit 1 picks low/high band, ignored for 1200/75 FSK standards
// - test bits 7:6 scrambler: 11 on with detector, 10 on without, 00 off
// - test functions stay off in this release; options still default to 193
// - calling bits 7:5 give levels 0..4 from codes 000,100,101,110,111
// - guard bits 7:6: 00 none, 11 550 Hz, 10 1800 Hz, high band PSK/QAM only
// - equaliser bit 0 tells crystal: 0 is 12.2880 MHz, 1 is 11.0592 MHz
// - equaliser bit 1 low enables the fixed compromise equalisers
// - equaliser bit 2 enables auto equaliser in PSK; always on in 2400 QAM
// - transmit gain bits 2:0, 111 is 0 dB, each step down 1.5 dB
// - transmit bits 5:3 give data 5..8 and stop 1..2, stop toggling first
// - transmit parity bits 7:6: 00 odd, 01 even, 10 none
// - receive gain bits 2:0 use the same 1.5 dB step code
// - receive bits 5:3 give data width, lowest bit says parity present
// - receive overspeed bits 7:6: 00 2.3 percent, 01 1 percent, 10 none
// - standard bits 7:4 hold selection codes 0 to 9
// - twist bits 2:0 non-monotonic code from +1.0 up to +4.5 dB
// - twist takes effect only when board modification state is 2 or more
`timescale 1ns/100ps
`default_nettype none
module modem_settings_register_bank
   import modem_settings_pkg::*;
#(
   parameter logic        bert_functions_present = 1'b0,
   parameter logic [15:0] fsk_1200_75_std_mask   = 16'h000c
)(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       wr_en,
   input  wire logic [4:0] wr_index,
   input  wire logic [7:0] wr_data,
   input  wire logic       rd_en,
   input  wire logic [4:0] rd_index,
   output logic      [7:0] rd_data,
   output logic            rd_valid,
   input  wire logic       recall_en,
   input  wire logic       recall_profile,
   input  wire logic [3:0] board_mod_state,
   input  wire logic       psk_mode_active,
   input  wire logic       qam_2400_active,
   input  wire logic       psk_qam_high_band,
   output logic      [7:0] long_timer_seconds,
   output logic      [7:0] short_timer_ticks,
   output logic            bert_enable,
   output logic            bert_transmit_end,
   output logic            bert_high_band,
   output logic            bert_scrambler_on,
   output logic            bert_ones_detect_on,
   output logic      [2:0] calling_level,
   output logic            calling_code_legal_flag,
   output logic      [1:0] guard_tone_sel,
   output logic            guard_tone_active,
   output logic            xtal_is_11m0592,
   output logic            fixed_eq_enable,
   output logic            auto_eq_enable,
   output logic      [4:0] tx_atten_half_db,
   output logic      [3:0] tx_data_bits,
   output logic      [1:0] tx_stop_bits,
   output logic      [1:0] tx_parity_mode,
   output logic      [4:0] rx_atten_half_db,
   output logic      [3:0] rx_data_bits,
   output logic            rx_parity_present,
   output logic      [1:0] rx_overspeed_mode,
   output logic      [3:0] line_standard,
   output logic            line_standard_legal,
   output logic      [3:0] twist_half_db
);

   // ***************************************************
   // state and access decode
   // ***************************************************
   bank_state_t state_q;
   bank_state_t state_d;
   logic [4:0]  wr_slot;
   logic [4:0]  rd_slot;
   logic        wr_hit;
   logic        rd_hit;

   // only settings in the bank answer; others read zero and ignore writes
   assign wr_slot = wr_index - idx_first;
   assign rd_slot = rd_index - idx_first;
   assign wr_hit  = (wr_index >= idx_first) && (wr_index <= idx_last);
   assign rd_hit  = (rd_index >= idx_first) && (rd_index <= idx_last);

   // ***************************************************
   // next state
   // ***************************************************
   // recall beats a write in the same cycle so a profile always lands whole
   always_comb begin
      state_d          = state_q;
      state_d.rd_valid = rd_en;
      if (recall_en) begin
         state_d.setting = recall_profile ? profile1_values
                                          : profile0_values;
      end else if (wr_en && wr_hit) begin
         state_d.setting[wr_slot[3:0]] = wr_data;
      end
      if (rd_en) begin
         state_d.rd_data = rd_hit ? state_q.setting[rd_slot[3:0]] : 8'h00;
      end
   end

   // register the whole state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q.setting  <= profile0_values;
         state_q.rd_data  <= 8'h00;
         state_q.rd_valid <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   assign rd_data  = state_q.rd_data;
   assign rd_valid = state_q.rd_valid;

   // ***************************************************
   // timers and bit-error test
   // ***************************************************
   logic [7:0] bert_q;
   logic [1:0] scr_code;
   logic [3:0] std_code;
   logic       std_is_fsk;

   assign bert_q             = state_q.setting[sl_bert_options];
   assign scr_code           = bert_q[two_bit_lsb +: 2];
   assign std_code           = state_q.setting[sl_line_standard][std_lsb +: 4];
   assign std_is_fsk         = fsk_1200_75_std_mask[std_code];
   assign long_timer_seconds = state_q.setting[sl_long_timer];
   assign short_timer_ticks  = state_q.setting[sl_short_timer];

   // the release gate forces every test output off, whatever is stored
   assign bert_enable         = bert_functions_present;
   assign bert_transmit_end   = bert_functions_present & bert_q[bert_end_bit];
   assign bert_high_band      = bert_functions_present & bert_q[bert_band_bit]
                                & ~std_is_fsk;
   assign bert_scrambler_on   = bert_functions_present
                                & ((scr_code == scr_on_detect)
                                   | (scr_code == scr_on_nodetect));
   assign bert_ones_detect_on = bert_functions_present
                                & (scr_code == scr_on_detect);

   // ***************************************************
   // calling, guard tone, equalisers
   // ***************************************************
   logic [2:0] call_code;
   logic [7:0] eq_q;

   // illegal calling codes behave as level 0 and are flagged
   assign call_code               = state_q.setting[sl_calling][calling_lsb +: 3];
   assign calling_level           = calling_level_table[call_code];
   assign calling_code_legal_flag = calling_code_legal[call_code];

   // the unused 01 code selects no tone
   always_comb begin
      guard_tone_sel = guard_none;
      if ((state_q.setting[sl_guard_tone][two_bit_lsb +: 2] == guard_550hz)
          || (state_q.setting[sl_guard_tone][two_bit_lsb +: 2] == guard_1800hz)) begin
         guard_tone_sel = state_q.setting[sl_guard_tone][two_bit_lsb +: 2];
      end
   end
   assign guard_tone_active = (guard_tone_sel != guard_none) & psk_qam_high_band;

   assign eq_q            = state_q.setting[sl_eq_clock];
   assign xtal_is_11m0592 = eq_q[eq_xtal_bit];
   assign fixed_eq_enable = ~eq_q[eq_fixed_bit];
   assign auto_eq_enable  = qam_2400_active
                            | (psk_mode_active & eq_q[eq_auto_bit]);

   // ***************************************************
   // transmit and receive character format
   // ***************************************************
   logic [7:0] txf_q;
   logic [7:0] rxf_q;
   logic [2:0] tx_char;
   logic [2:0] rx_char;

   assign txf_q   = state_q.setting[sl_tx_format];
   assign rxf_q   = state_q.setting[sl_rx_format];
   assign tx_char = txf_q[fmt_char_lsb +: 3];
   assign rx_char = rxf_q[fmt_char_lsb +: 3];

   // one decoder per direction keeps the two gain scales identical
   gain_step_decoder u_tx_gain (
      .code          (txf_q[fmt_gain_lsb +: 3]),
      .atten_half_db (tx_atten_half_db)
   );

   gain_step_decoder u_rx_gain (
      .code          (rxf_q[fmt_gain_lsb +: 3]),
      .atten_half_db (rx_atten_half_db)
   );

   assign tx_data_bits      = min_data_bits + {2'h0, tx_char[2:1]};
   assign tx_stop_bits      = min_stop_bits + {1'b0, tx_char[0]};
   assign rx_data_bits      = min_data_bits + {2'h0, rx_char[2:1]};
   assign rx_parity_present = rx_char[0];

   // unused 11 codes fall back to no parity and no overspeed
   always_comb begin
      tx_parity_mode = parity_none;
      if (txf_q[two_bit_lsb +: 2] != 2'h3) begin
         tx_parity_mode = txf_q[two_bit_lsb +: 2];
      end
      rx_overspeed_mode = ospeed_none;
      if (rxf_q[two_bit_lsb +: 2] != 2'h3) begin
         rx_overspeed_mode = rxf_q[two_bit_lsb +: 2];
      end
   end

   // ***************************************************
   // line standard and tone-dial twist
   // ***************************************************
   assign line_standard       = std_code;
   assign line_standard_legal = (std_code <= std_max_code);

   // older boards cannot set twist, so they report the default level
   assign twist_half_db = (board_mod_state >= board_mod_min)
                          ? twist_half_db_table[state_q.setting[sl_twist][twist_lsb +: 3]]
                          : twist_half_db_table[twist_default];

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_recall_profile1;
      recall_en && recall_profile |=> (eq_q == 8'h03) && (rxf_q == 8'hb0)
                                      && (long_timer_seconds == 8'h1e);
   endproperty
   a_recall_profile1 : assert property (p_recall_profile1)
      else $error("profile 1 recall values wrong");

   property p_recall_profile0;
      recall_en && !recall_profile |=> (eq_q == 8'h01) && (rxf_q == 8'h30)
                                       && (bert_q == 8'hc1) && (short_timer_ticks == 8'h02);
   endproperty
   a_recall_profile0 : assert property (p_recall_profile0)
      else $error("profile 0 recall values wrong");

   property p_bert_off;
      !bert_functions_present |-> !bert_enable && !bert_scrambler_on && !bert_transmit_end;
   endproperty
   a_bert_off : assert property (p_bert_off)
      else $error("test functions active in this release");

   property p_xtal_write;
      wr_en && !recall_en && (wr_index == idx_eq_clock)
         |=> xtal_is_11m0592 == $past(wr_data[0]) && fixed_eq_enable == !$past(wr_data[1]);
   endproperty
   a_xtal_write : assert property (p_xtal_write)
      else $error("crystal or fixed equaliser not following write");

   property p_auto_eq_qam;
      qam_2400_active |-> auto_eq_enable;
   endproperty
   a_auto_eq_qam : assert property (p_auto_eq_qam)
      else $error("auto equaliser off in 2400 QAM");

   property p_tx_gain_top;
      wr_en && !recall_en && (wr_index == idx_tx_format) && (wr_data[2:0] == 3'h7)
         |=> tx_atten_half_db == 5'h00;
   endproperty
   a_tx_gain_top : assert property (p_tx_gain_top)
      else $error("top transmit gain code not 0 dB");

   property p_rx_gain_bottom;
      wr_en && !recall_en && (wr_index == idx_rx_format) && (wr_data[2:0] == 3'h0)
         |=> rx_atten_half_db == 5'h15;
   endproperty
   a_rx_gain_bottom : assert property (p_rx_gain_bottom)
      else $error("lowest receive gain code not -10.5 dB");

   property p_tx_char_range;
      (tx_data_bits >= 4'h5) && (tx_data_bits <= 4'h8)
         && (tx_stop_bits >= 2'h1) && (tx_stop_bits <= 2'h2);
   endproperty
   a_tx_char_range : assert property (p_tx_char_range)
      else $error("transmit character format out of range");

   property p_old_board_twist;
      board_mod_state < 4'h2 |-> twist_half_db == 4'h4;
   endproperty
   a_old_board_twist : assert property (p_old_board_twist)
      else $error("twist changed on an old board");

   property p_spare_readback;
      wr_en && !recall_en && (wr_index == idx_spare_a) ##1
         !(wr_en && (wr_index == idx_spare_a)) && !recall_en ##1
         (rd_en && (rd_index == idx_spare_a) && !(wr_en && (wr_index == idx_spare_a))
          && !recall_en) |=> rd_valid && (rd_data == $past(wr_data, 3));
   endproperty
   a_spare_readback : assert property (p_spare_readback)
      else $error("reserved setting did not read back");

   property p_fsk_band;
      std_is_fsk |-> !bert_high_band;
   endproperty
   a_fsk_band : assert property (p_fsk_band)
      else $error("band bit used for FSK standard");

   property p_calling_level;
      calling_level <= 3'h4;
   endproperty
   a_calling_level : assert property (p_calling_level)
      else $error("calling level above 4");

   property p_read_answer;
      rd_en |=> rd_valid;
   endproperty
   a_read_answer : assert property (p_read_answer)
      else $error("read not answered");

   property p_read_pulse;
      !rd_en |=> !rd_valid;
   endproperty
   a_read_pulse : assert property (p_read_pulse)
      else $error("read valid too long");

   property p_unmapped_read;
      rd_en && (rd_index > idx_last) |=> rd_data == 8'h00;
   endproperty
   a_unmapped_read : assert property (p_unmapped_read)
      else $error("unmapped read nonzero");

   property p_guard_band;
      !psk_qam_high_band |-> !guard_tone_active;
   endproperty
   a_guard_band : assert property (p_guard_band)
      else $error("guard tone in low band");

   c_recall1 : cover property (recall_en && recall_profile ##1 rd_en);
   c_twist_on : cover property (board_mod_state >= 4'h2 && twist_half_db == 4'h9);
   c_guard : cover property (guard_tone_active && guard_tone_sel == guard_1800hz);
   c_bad_call : cover property (!calling_code_legal_flag);
   c_old_board : cover property (board_mod_state < 4'h2);

endmodule : modem_settings_register_bank
`default_nettype wire

//--- tb/host_terminal_model.sv
// host terminal model: sends setting writes, reads and profile recalls
`timescale 1ns/100ps
`default_nettype none
module host_terminal_model (
   input  wire logic       clk,
   output logic            wr_en,
   output logic      [4:0] wr_index,
   output logic      [7:0] wr_data,
   output logic            rd_en,
   output logic      [4:0] rd_index,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_valid,
   output logic            recall_en,
   output logic            recall_profile
);
   logic [2:0] tx_gain_q = 3'h0;  // shadow of the transmit gain code last sent

   // idle levels before the first command
   initial begin
      {wr_en, rd_en, recall_en, recall_profile} = 4'h0;
      {wr_index, rd_index, wr_data} = 18'h00000;
   end

   // one setting write; released lines show the inverse, never a held value
   task automatic write(input logic [4:0] idx, input logic [7:0] val);
      // a nondefault twist is never sent while the last transmit gain code sent is 0 dB
      if (idx == 5'h1c && val[2:0] != 3'h0 && tx_gain_q == 3'h7) begin
         return;
      end
      if (idx == 5'h19) begin
         tx_gain_q = val[2:0];
      end
      @(negedge clk);
      wr_index = idx;
      wr_data = val;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
      wr_index = ~idx;
      wr_data = ~val;
   endtask : write

   // read answer comes exactly one cycle after the request edge
   task automatic read(input logic [4:0] idx, output logic [7:0] val, output logic vld);
      @(negedge clk);
      rd_index = idx;
      rd_en = 1'b1;
      @(negedge clk);
      rd_en = 1'b0;
      rd_index = ~idx;
      vld = rd_valid;
      val = rd_data;
   endtask : read

   // profile recall strobe
   task automatic recall(input logic p);
      @(negedge clk);
      recall_profile = p;
      recall_en = 1'b1;
      @(negedge clk);
      recall_en = 1'b0;
      recall_profile = ~p;
   endtask : recall
endmodule : host_terminal_model
`default_nettype wire

//--- tb/modem_settings_register_bank_tb.sv
// self-checking bench of the modem settings bank
`timescale 1ns/100ps
`default_nettype none
module modem_settings_register_bank_tb;
   typedef struct packed {
      logic [4:0] idx;
      logic [7:0] wdat;
      logic [3:0] k;
      logic [7:0] exp;
   } row_t;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [3:0] board_mod_state = 4'h2;
   logic       psk_mode_active = 1'b1, qam_2400_active = 1'b0, psk_qam_high_band = 1'b1;
   logic       wr_en, rd_en, rd_valid, recall_en, recall_profile, vld;
   logic [4:0] wr_index, rd_index;
   logic [7:0] wr_data, rd_data, long_timer_seconds, short_timer_ticks, got;
   logic       bert_enable, bert_transmit_end, bert_high_band, bert_scrambler_on;
   logic       bert_ones_detect_on, calling_code_legal_flag, guard_tone_active;
   logic       xtal_is_11m0592, fixed_eq_enable, auto_eq_enable, rx_parity_present;
   logic       line_standard_legal;
   logic [2:0] calling_level;
   logic [1:0] guard_tone_sel, tx_stop_bits, tx_parity_mode, rx_overspeed_mode;
   logic [4:0] tx_atten_half_db, rx_atten_half_db;
   logic [3:0] tx_data_bits, rx_data_bits, line_standard, twist_half_db;
   int         err_total = 0, comparisons = 0, cycles = 0;
   // ***************************************************
   // expected values: write, observed field, its value
   // ***************************************************
   row_t rows [$] = '{
      '{5'h12,8'hff,4'h0,8'hff}, '{5'h14,8'h5a,4'h0,8'hff}, '{5'h1d,8'ha5,4'h0,8'hff},
      '{5'h13,8'h00,4'h1,8'h00}, '{5'h15,8'hc3,4'h2,8'h00}, '{5'h16,8'h00,4'h3,8'h08},
      '{5'h16,8'h80,4'h3,8'h09}, '{5'h16,8'ha0,4'h3,8'h0a}, '{5'h16,8'hc0,4'h3,8'h0b},
      '{5'h16,8'he0,4'h3,8'h0c}, '{5'h16,8'h1f,4'h3,8'h08}, '{5'h16,8'h20,4'h3,8'h00},
      '{5'h17,8'hc0,4'h4,8'h07}, '{5'h17,8'h80,4'h4,8'h06}, '{5'h17,8'h00,4'h4,8'h00},
      '{5'h18,8'h00,4'h5,8'h02}, '{5'h18,8'h07,4'h5,8'h05}, '{5'h19,8'h07,4'h6,8'h00},
      '{5'h19,8'h00,4'h6,8'h15}, '{5'h19,8'h05,4'h6,8'h06}, '{5'h19,8'h38,4'h7,8'h28},
      '{5'h19,8'h08,4'h7,8'h25}, '{5'h19,8'h10,4'h7,8'h16}, '{5'h19,8'h00,4'h7,8'h15},
      '{5'h19,8'h40,4'h8,8'h01}, '{5'h19,8'h80,4'h8,8'h02}, '{5'h19,8'h00,4'h8,8'h00},
      '{5'h1a,8'h07,4'h9,8'h00}, '{5'h1a,8'h03,4'h9,8'h0c}, '{5'h1a,8'h38,4'ha,8'h18},
      '{5'h1a,8'h28,4'ha,8'h17}, '{5'h1a,8'h00,4'ha,8'h05}, '{5'h1a,8'h40,4'hb,8'h01},
      '{5'h1a,8'h80,4'hb,8'h02}, '{5'h1a,8'h00,4'hb,8'h00}, '{5'h1b,8'h90,4'hc,8'h19},
      '{5'h1b,8'ha0,4'hc,8'h0a}, '{5'h1b,8'h00,4'hc,8'h10}, '{5'h1c,8'h00,4'hd,8'h04},
      '{5'h1c,8'h01,4'hd,8'h02}, '{5'h1c,8'h02,4'hd,8'h03}, '{5'h1c,8'h03,4'hd,8'h05},
      '{5'h1c,8'h04,4'hd,8'h06}, '{5'h1c,8'h05,4'hd,8'h07}, '{5'h1c,8'h06,4'hd,8'h08},
      '{5'h1c,8'h07,4'hd,8'h09}};
   // profile 0 and profile 1 contents of settings 18 to 29
   logic [7:0] prof [0:1][0:11] = '{
      '{8'h1e, 8'h02, 8'h00, 8'hc1, 8'h00, 8'h00, 8'h01, 8'hb0, 8'h30, 8'h00, 8'h00, 8'h00},
      '{8'h1e, 8'h02, 8'h00, 8'hc1, 8'h00, 8'h00, 8'h03, 8'hb0, 8'hb0, 8'h00, 8'h00, 8'h00}};

   modem_settings_register_bank i_modem_settings_register_bank (.clk, .rst, .wr_en, .wr_index,
      .wr_data, .rd_en, .rd_index, .rd_data, .rd_valid, .recall_en, .recall_profile,
      .board_mod_state, .psk_mode_active, .qam_2400_active, .psk_qam_high_band,
      .long_timer_seconds, .short_timer_ticks, .bert_enable, .bert_transmit_end, .bert_high_band,
      .bert_scrambler_on, .bert_ones_detect_on, .calling_level, .calling_code_legal_flag,
      .guard_tone_sel, .guard_tone_active, .xtal_is_11m0592, .fixed_eq_enable, .auto_eq_enable,
      .tx_atten_half_db, .tx_data_bits, .tx_stop_bits, .tx_parity_mode, .rx_atten_half_db,
      .rx_data_bits, .rx_parity_present, .rx_overspeed_mode, .line_standard,
      .line_standard_legal, .twist_half_db);
   host_terminal_model i_host_terminal_model (.clk, .wr_en, .wr_index, .wr_data, .rd_en,
      .rd_index, .rd_data, .rd_valid, .recall_en, .recall_profile);

   always #2 clk = ~clk;  // 250 MHz

   // the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         final_report();
      end
   end

   // gathers one decoded field, zero extended to a byte
   function automatic logic [7:0] obs(input logic [3:0] k);
      case (k)
         4'h0: obs = long_timer_seconds;
         4'h1: obs = short_timer_ticks;
         4'h2: obs = {3'h0, bert_enable, bert_transmit_end, bert_high_band, bert_scrambler_on,
                      bert_ones_detect_on};
         4'h3: obs = {4'h0, calling_code_legal_flag, calling_level};
         4'h4: obs = {5'h0, guard_tone_active, guard_tone_sel};
         4'h5: obs = {5'h0, auto_eq_enable, fixed_eq_enable, xtal_is_11m0592};
         4'h6: obs = {3'h0, tx_atten_half_db};
         4'h7: obs = {2'h0, tx_stop_bits, tx_data_bits};
         4'h8: obs = {6'h0, tx_parity_mode};
         4'h9: obs = {3'h0, rx_atten_half_db};
         4'ha: obs = {3'h0, rx_parity_present, rx_data_bits};
         4'hb: obs = {6'h0, rx_overspeed_mode};
         4'hc: obs = {3'h0, line_standard_legal, line_standard};
         default: obs = {4'h0, twist_half_db};
      endcase
   endfunction : obs

   task automatic chk(input logic [7:0] g, input logic [7:0] e, input string what);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
      end
   endtask : chk

   // a read must answer with valid and the expected byte
   task automatic rdchk(input logic [4:0] idx, input logic [7:0] e);
      i_host_terminal_model.read(idx, got, vld);
      chk({7'h00, vld}, 8'h01, "read valid");
      chk(got, e, "read data");
   endtask : rdchk

   task automatic check_all(input logic p);
      for (int i = 0; i < 12; i++) begin
         rdchk(5'h12 + 5'(i), prof[p][i]);
      end
   endtask : check_all

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report

   // table first, then the awkward cases by hand
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      foreach (rows[i]) begin
         i_host_terminal_model.write(rows[i].idx, rows[i].wdat);
         chk(obs(rows[i].k), rows[i].exp, "decoded field");
         rdchk(rows[i].idx, rows[i].wdat);
      end
      $display("test table finished");
      board_mod_state = 4'h1;
      @(negedge clk);
      chk(obs(4'hd), 8'h04, "twist on old board");
      board_mod_state = 4'h2;
      {qam_2400_active, psk_mode_active, psk_qam_high_band} = 3'b100;
      i_host_terminal_model.write(5'h18, 8'h00);
      chk(obs(4'h5), 8'h06, "auto eq in qam");
      i_host_terminal_model.write(5'h17, 8'hc0);
      chk(obs(4'h4), 8'h03, "guard tone low band");
      $display("test line modes finished");
      rdchk(5'h11, 8'h00);
      rdchk(5'h1e, 8'h00);
      $display("test unmapped finished");
      i_host_terminal_model.recall(1'b1);
      check_all(1'b1);
      i_host_terminal_model.recall(1'b0);
      check_all(1'b0);
      $display("test recall finished");
      i_host_terminal_model.write(5'h19, 8'h07);
      rst = 1'b1;
      repeat (3) @(negedge clk);
      chk({7'h00, rd_valid}, 8'h00, "valid in reset");
      rst = 1'b0;
      check_all(1'b0);
      $display("test reset finished");
      final_report();
   end
endmodule : modem_settings_register_bank_tb
`default_nettype wire
